//--- src/sdr_defs.vh
// Constants shared by the status, diagnostic and readback block
`ifndef SDR_DEFS_VH
`define SDR_DEFS_VH

`define SDR_FRAME_BITS 16
`define SDR_ADDR_W 5
`define SDR_DATA_W 9
`define SDR_RB_W 10
`define SDR_ADDR_CFG 5'h1d
`define SDR_ADDR_RB 5'h1f
`define SDR_CNT_FULL 5'h10
`define SDR_CNT_OVER 5'h11
`define SDR_CNT_ADDR 5'h05
`define SDR_CNT_WR 5'h06

// Status word bit positions
`define SDR_ST_FF 15
`define SDR_ST_POR 14
`define SDR_ST_SE 13
`define SDR_ST_CRIT 12
`define SDR_ST_CUR 11
`define SDR_ST_AUX 10
`define SDR_ST_MON_HI 9
`define SDR_ST_MON_LO 3
`define SDR_ST_BU 2
`define SDR_ST_VO 1

// Diagnostic word: bit 9 overspeed, 8:6 bootstrap A..C, 5:0 AH AL BH BL CH CL
`define SDR_DG_OSR 9
`define SDR_DG_BOOT_HI 8
`define SDR_DG_BOOT_LO 6
`define SDR_DG_VDS_HI 5
`define SDR_DG_VDS_LO 0

// Readback select configuration register fields (data bits 8:0)
`define SDR_CFG_RBS_HI 2
`define SDR_CFG_RBS_LO 0
`define SDR_CFG_CKS 3
`define SDR_CFG_LBR 4
`define SDR_CFG_DSR 5
`define SDR_CFG_DGS_HI 7
`define SDR_CFG_DGS_LO 6
`define SDR_CFG_RST 9'h000

// Readback selections
`define SDR_RBS_DIAG 3'h0
`define SDR_RBS_SPEED 3'h1
`define SDR_RBS_CURR 3'h2
`define SDR_RBS_VOLT 3'h3
`define SDR_RBS_TEMP 3'h4
`define SDR_RBS_DEMAND 3'h5
`define SDR_RBS_DUTY 3'h6
`define SDR_RBS_ADV 3'h7

// Pin synchroniser idle levels: strobe_n, sclk, sdi
`define SDR_PIN_IDLE 3'h7

// Measurement refresh period
`define SDR_CLK_KHZ 25000
`define SDR_REFRESH_MS 2
`define SDR_REFRESH_CYC (`SDR_REFRESH_MS * `SDR_CLK_KHZ)

`endif

//--- src/sdr_sample_hold.v
// Sample-and-hold register refreshed by a load pulse
`timescale 1ns/1ps
`default_nettype none
module sdr_sample_hold #(
  parameter W = 10
) (
  input wire clk_sys_i, // System clock
  input wire srst_i, // Synchronous reset
  input wire load_i, // Refresh pulse
  input wire [W-1:0] d_i, // Live value
  output wire [W-1:0] q_o // Held value
);
  reg [W-1:0] hold_q;

  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      hold_q <= {W{1'b0}};
    end else if (load_i) begin
      hold_q <= d_i;
    end
  end

  assign q_o = hold_q;
endmodule
`default_nettype wire

//--- src/sdr_status_diag_readback.v
// Serial status, diagnostic and measurement readback block
`timescale 1ns/1ps
`default_nettype none
`include "sdr_defs.vh"
module sdr_status_diag_readback #(
  parameter REFRESH_CYC = `SDR_REFRESH_CYC
) (
  input wire clk_sys_i, // System clock, 25 MHz
  input wire srst_i, // Power-on reset, synchronous
  input wire strobe_n_i, // Serial strobe pin, active low
  input wire sclk_i, // Serial clock pin
  input wire serial_data_in_i, // Serial data in pin
  output wire serial_data_out_o, // Serial data out
  output wire serial_data_oe_o, // Serial data out enable
  output wire fault_flag_o, // Summary fault flag level
  output wire [4:0] reg_addr_o, // Address of external register
  output wire [8:0] reg_wdata_o, // Write data to external register
  output wire reg_wr_o, // Write pulse to external register
  input wire [8:0] reg_rdata_i, // Read data of addressed register
  output wire [8:0] cfg_readback_o, // Readback select configuration register
  input wire [1:0] crit_fault_i, // Faults for status bits 12 and 10
  input wire [6:0] monitor_fault_i, // Monitor faults for status bits 9..3
  input wire current_ctrl_i, // Current control state
  input wire [2:0] bootstrap_uv_i, // Bootstrap undervoltage, phases A..C
  input wire [5:0] vds_ov_i, // Overvoltage AH AL BH BL CH CL
  input wire overspeed_i, // Speed above maximum reference
  input wire nvm_fault_i, // User values not loaded
  input wire [9:0] speed_i, // Speed in resolution steps
  input wire [9:0] avg_current_i, // Average supply current
  input wire [9:0] supply_volt_i, // Supply voltage
  input wire [9:0] chip_temp_i, // Chip temperature
  input wire [9:0] demand_value_i, // Present demand value
  input wire [9:0] peak_duty_i, // Applied peak duty
  input wire [9:0] phase_adv_i, // Applied phase advance
  input wire pwm_period_i // Bridge PWM period pulse
);
  localparam ST_IDLE = 2'b01;
  localparam ST_XFER = 2'b10;
  localparam [31:0] REFRESH_M1 = REFRESH_CYC - 1;
  localparam [16:0] REFRESH_LAST = REFRESH_M1[16:0];

  function odd_ones;
    input [15:0] w;
    begin
      odd_ones = ^w;
    end
  endfunction

  // Pins pass two flops; edges compare the second flop with one more stage
  wire [2:0] pins_s;
  reg [2:0] pins_prev_q;
  sdr_sync #(
    .W(3),
    .RST_VAL(`SDR_PIN_IDLE)
  ) u_sync (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .d_i({strobe_n_i, sclk_i, serial_data_in_i}),
    .q_o(pins_s)
  );

  wire stb_s = pins_s[2];
  wire sck_s = pins_s[1];
  wire sdi_s = pins_s[0];
  wire stb_fall = pins_prev_q[2] & ~stb_s;
  wire stb_rise = ~pins_prev_q[2] & stb_s;
  wire sck_rise = ~pins_prev_q[1] & sck_s;
  wire sck_fall = pins_prev_q[1] & ~sck_s;

  // Measurement refresh
  // Free-running divider, so a readback never waits on a refresh
  reg [16:0] refresh_cnt_q;
  wire refresh_tick = (refresh_cnt_q == REFRESH_LAST);
  wire [29:0] slow_meas;
  wire [19:0] pwm_meas;

  sdr_sample_hold #(
    .W(30)
  ) u_slow_hold (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .load_i(refresh_tick),
    .d_i({avg_current_i, supply_volt_i, chip_temp_i}),
    .q_o(slow_meas)
  );

  sdr_sample_hold #(
    .W(20)
  ) u_pwm_hold (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .load_i(pwm_period_i),
    .d_i({peak_duty_i, phase_adv_i}),
    .q_o(pwm_meas)
  );

  // Fault state
  reg por_q;
  reg se_q;
  reg [8:0] lat_q;
  reg [8:0] diag_q;
  reg [8:0] cfg_q;
  reg [15:0] snap_q;
  reg [8:0] snap_dg_q;

  wire bu_sum = |diag_q[`SDR_DG_BOOT_HI:`SDR_DG_BOOT_LO];
  wire vo_sum = |diag_q[`SDR_DG_VDS_HI:`SDR_DG_VDS_LO];
  wire ff = por_q | se_q | (|lat_q) | bu_sum | vo_sum;
  wire [15:0] status_w = {ff, por_q, se_q, lat_q[8], current_ctrl_i, lat_q[7:0],
                          bu_sum, vo_sum, 1'b0};
  wire [9:0] diag_w = {overspeed_i, diag_q};
  wire [8:0] lat_now = {crit_fault_i, monitor_fault_i};
  wire [8:0] diag_now = {bootstrap_uv_i, vds_ov_i};
  wire [2:0] readback_select = cfg_q[`SDR_CFG_RBS_HI:`SDR_CFG_RBS_LO];
  wire dsr = cfg_q[`SDR_CFG_DSR];

  // Sampled at the fifth rise, so the value cannot move inside a frame
  reg [9:0] rb_value;
  always @* begin
    rb_value = diag_w;
    case (readback_select)
      `SDR_RBS_DIAG: rb_value = diag_w;
      `SDR_RBS_SPEED: rb_value = speed_i;
      `SDR_RBS_CURR: rb_value = slow_meas[29:20];
      `SDR_RBS_VOLT: rb_value = slow_meas[19:10];
      `SDR_RBS_TEMP: rb_value = slow_meas[9:0];
      `SDR_RBS_DEMAND: rb_value = demand_value_i;
      `SDR_RBS_DUTY: rb_value = pwm_meas[19:10];
      `SDR_RBS_ADV: rb_value = pwm_meas[9:0];
      default: rb_value = diag_w;
    endcase
  end

  // Serial transfer
  // Status bits come from the snapshot taken at strobe fall, so a flag
  // that changes during a frame shows up in the next one
  reg [1:0] state_q;
  reg [4:0] cnt_q;
  reg [15:0] rx_q;
  reg [15:0] tx_q;
  reg sdo_q;
  reg oe_q;
  reg [4:0] addr_q;
  reg [8:0] wdata_q;
  reg wr_q;
  reg diag_sel_q;

  wire [4:0] addr_now = {rx_q[3:0], sdi_s};
  wire [4:0] frame_addr = rx_q[4:0];
  wire is_rb = (frame_addr == `SDR_ADDR_RB);
  wire [8:0] rd_data = (frame_addr == `SDR_ADDR_CFG) ? cfg_q : reg_rdata_i;
  wire [14:0] body = is_rb ? {snap_q[15:11], tx_q[10], tx_q[9:1]} :
                     {snap_q[15:11], 1'b0, (sdi_s ? snap_q[9:1] : rd_data)};
  wire [9:0] rb_hold_w = {tx_q[10], tx_q[9:1]};
  wire xfer_end = (state_q == ST_XFER) & stb_rise;
  wire frame_ok = (cnt_q == `SDR_CNT_FULL) & odd_ones(rx_q);
  wire xfer_err = xfer_end & (cnt_q != 5'h00) & ~frame_ok;
  wire valid_end = xfer_end & frame_ok;
  wire frame_wr = rx_q[10];
  wire frame_rb = (rx_q[15:11] == `SDR_ADDR_RB);
  // A status read is any valid write frame away from the readback address while dsr is clear
  wire clr_status = valid_end & frame_wr & ~frame_rb & ~dsr;
  wire clr_diag = valid_end & frame_rb & diag_sel_q & ~dsr;

  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      pins_prev_q <= `SDR_PIN_IDLE;
      refresh_cnt_q <= 17'h00000;
      state_q <= ST_IDLE;
      cnt_q <= 5'h00;
      rx_q <= 16'h0000;
      tx_q <= 16'h0000;
      sdo_q <= 1'b0;
      oe_q <= 1'b0;
      addr_q <= 5'h00;
      wdata_q <= 9'h000;
      wr_q <= 1'b0;
      diag_sel_q <= 1'b0;
      snap_q <= 16'h0000;
      snap_dg_q <= 9'h000;
    end else begin
      pins_prev_q <= pins_s;
      refresh_cnt_q <= refresh_tick ? 17'h00000 : refresh_cnt_q + 17'h00001;
      wr_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (stb_fall) begin
            state_q <= ST_XFER;
            cnt_q <= 5'h00;
            snap_q <= status_w;
            snap_dg_q <= diag_q;
            tx_q <= {status_w[15:11], 11'h000};
            sdo_q <= status_w[`SDR_ST_FF];
            oe_q <= 1'b1;
          end
        end
        ST_XFER: begin
          if (stb_rise) begin
            state_q <= ST_IDLE;
            oe_q <= 1'b0;
            if (valid_end & frame_wr & ~frame_rb & (rx_q[15:11] != `SDR_ADDR_CFG)) begin
              addr_q <= rx_q[15:11];
              wdata_q <= rx_q[9:1];
              wr_q <= 1'b1;
            end
          end else begin
            if (sck_rise) begin
              rx_q <= {rx_q[14:0], sdi_s};
              if (cnt_q != `SDR_CNT_OVER) begin
                cnt_q <= cnt_q + 5'h01;
              end
              if (cnt_q == `SDR_CNT_ADDR - 5'h01) begin
                addr_q <= addr_now;
                diag_sel_q <= (readback_select == `SDR_RBS_DIAG);
                if (addr_now == `SDR_ADDR_RB) begin
                  tx_q[10:1] <= rb_value;
                end else begin
                  tx_q[10] <= 1'b0;
                end
              end
              if (cnt_q == `SDR_CNT_WR - 5'h01) begin
                tx_q <= {body, ~odd_ones({1'b0, body})};
              end
            end
            // Bits move after each fall so the master can sample on the rise
            if (sck_fall && cnt_q != 5'h00 && cnt_q < `SDR_CNT_FULL) begin
              sdo_q <= tx_q[4'hf - cnt_q[3:0]];
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
          oe_q <= 1'b0;
        end
      endcase
    end
  end

  // Flag latching: a fault present in the clearing cycle wins over the clear
  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      por_q <= 1'b1;
      se_q <= 1'b0;
      lat_q <= 9'h000;
      diag_q <= 9'h000;
      cfg_q <= `SDR_CFG_RST;
    end else begin
      lat_q <= (lat_q & ~(clr_status ? {snap_q[12], snap_q[10:3]} : 9'h000)) | lat_now;
      diag_q <= (diag_q & ~(clr_diag ? snap_dg_q : 9'h000)) | diag_now;
      if (clr_status & snap_q[`SDR_ST_POR]) begin
        por_q <= 1'b0;
      end
      se_q <= (se_q & ~(clr_status & snap_q[`SDR_ST_SE])) | xfer_err | (por_q & nvm_fault_i);
      // The select register is local, so writing it never pulses reg_wr_o
      if (valid_end & frame_wr & (rx_q[15:11] == `SDR_ADDR_CFG)) begin
        cfg_q <= rx_q[9:1];
      end
    end
  end

  assign serial_data_out_o = sdo_q;
  assign serial_data_oe_o = oe_q;
  assign fault_flag_o = ff;
  assign reg_addr_o = addr_q;
  assign reg_wdata_o = wdata_q;
  assign reg_wr_o = wr_q;
  assign cfg_readback_o = cfg_q;

  wire unused_ok = &{1'b0, rb_hold_w, frame_addr[0]};
endmodule
`default_nettype wire

//--- src/sdr_sync.v
// Two-stage synchroniser for serial pins
`timescale 1ns/1ps
`default_nettype none
module sdr_sync #(
  parameter W = 3,
  parameter [W-1:0] RST_VAL = {W{1'b1}}
) (
  input wire clk_sys_i, // System clock
  input wire srst_i, // Synchronous reset
  input wire [W-1:0] d_i, // Asynchronous inputs
  output wire [W-1:0] q_o // Synchronised outputs
);
  reg [W-1:0] meta_q;
  reg [W-1:0] sync_q;

  always @(posedge clk_sys_i) begin
    if (srst_i) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule
`default_nettype wire

//--- testbench/sdr_link_master.sv
// Serial master model standing in for the external controller
`timescale 1ns/1ps
`default_nettype none
module sdr_link_master (
  input wire logic clk_sys_i, // Clock used only for alignment
  output logic strobe_n_o, // Strobe, active low
  output logic sclk_o, // Link clock, idle high
  output logic sdi_o, // Data to the block
  input wire logic sdo_i, // Data from the block
  input wire logic oe_i // Block drives data out
);
  initial begin
    strobe_n_o = 1'b1;
    sclk_o = 1'b1;
    sdi_o = 1'b0;
  end
  // Bits are taken late in each cycle, as the block answers a few clocks after each fall
  task automatic xfer(input logic [15:0] w, input int n, input bit bad, output logic [15:0] r);
    int i;
    r = 16'hxxxx;
    w[0] = ~^w[15:1] ^ bad;
    @(posedge clk_sys_i);
    #1 strobe_n_o = 1'b0;
    #320;
    for (i = 0; i < n; i++) begin
      sclk_o = 1'b0;
      sdi_o = (i < 16) ? w[15-i] : ~sdi_o;
      #160 sclk_o = 1'b1;
      #160;
      if (i < 16) r[15-i] = oe_i ? sdo_i : 1'bx;
    end
    if (n == 0) r[15] = oe_i ? sdo_i : 1'bx;
    strobe_n_o = 1'b1;
    sdi_o = ~sdi_o;
    #320;
  endtask
endmodule
`default_nettype wire

//--- testbench/sdr_status_diag_readback_asserts.sv
// Assertion checker for the status, diagnostic and readback block
`timescale 1ns/1ps
`default_nettype none
module sdr_asserts #(
  parameter REFRESH_CYC = 50000
) (
  input wire logic clk_sys_i, // System clock
  input wire logic srst_i, // Reset
  input wire logic strobe_n_i, // Strobe pin
  input wire logic serial_data_out_o, // Data out
  input wire logic serial_data_oe_o, // Data out enable
  input wire logic fault_flag_o, // Fault flag
  input wire logic [4:0] reg_addr_o, // Register address
  input wire logic reg_wr_o, // Write pulse
  input wire logic [8:0] cfg_readback_o, // Select register
  input wire logic [1:0] crit_fault_i, // Critical faults
  input wire logic [6:0] monitor_fault_i, // Monitor faults
  input wire logic [2:0] bootstrap_uv_i, // Bootstrap faults
  input wire logic [5:0] vds_ov_i // Overvoltage faults
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  sequence s_start;
    $fell(strobe_n_i);
  endsequence
  sequence s_stop;
    $rose(strobe_n_i);
  endsequence
  a_oe_on_start: assert property (s_start |-> ##[2:5] serial_data_oe_o)
    else $error("data out not driven after strobe fall");
  a_oe_off_stop: assert property (s_stop |-> ##[2:5] !serial_data_oe_o)
    else $error("data out not released after strobe rise");
  a_first_bit_ff: assert property ($rose(serial_data_oe_o) |-> serial_data_out_o == fault_flag_o)
    else $error("first bit is not the fault flag");
  a_wr_one_cycle: assert property (reg_wr_o |=> !reg_wr_o)
    else $error("write pulse longer than one cycle");
  a_wr_legal_addr: assert property (reg_wr_o |-> strobe_n_i && reg_addr_o != 5'h1f && reg_addr_o != 5'h1d)
    else $error("write pulse at wrong time or address");
  a_cfg_between_frames: assert property ($changed(cfg_readback_o) |-> strobe_n_i)
    else $error("select register changed inside a frame");
  a_por_after_rst: assert property ($fell(srst_i) |-> fault_flag_o && !serial_data_oe_o)
    else $error("fault flag low after reset");
  a_fault_latch: assert property ((|crit_fault_i || |monitor_fault_i) |-> ##[1:2] fault_flag_o)
    else $error("status fault not flagged");
  a_bridge_fault: assert property ((|bootstrap_uv_i || |vds_ov_i) |-> ##[1:2] fault_flag_o)
    else $error("bridge fault not flagged");
endmodule
bind sdr_status_diag_readback sdr_asserts #(.REFRESH_CYC(REFRESH_CYC)) i_chk (
  .clk_sys_i(clk_sys_i), .srst_i(srst_i), .strobe_n_i(strobe_n_i),
  .serial_data_out_o(serial_data_out_o), .serial_data_oe_o(serial_data_oe_o),
  .fault_flag_o(fault_flag_o), .reg_addr_o(reg_addr_o), .reg_wr_o(reg_wr_o),
  .cfg_readback_o(cfg_readback_o), .crit_fault_i(crit_fault_i),
  .monitor_fault_i(monitor_fault_i), .bootstrap_uv_i(bootstrap_uv_i), .vds_ov_i(vds_ov_i));
`default_nettype wire

//--- testbench/sdr_status_diag_readback_tb.sv
// Self-checking testbench for the status, diagnostic and readback block
`timescale 1ns/1ps
`default_nettype none
module sdr_status_diag_readback_tb;
  localparam int RCYC = 400;
  logic clk_sys_i = 1'b0, srst_i = 1'b1, strobe_n, sclk, serial_data_in, serial_data_out, oe, ff, wr;
  logic [8:0] rdata = 9'h0a5, cfg, wdata, wr_data;
  logic [4:0] addr, wr_addr;
  logic [1:0] crit = '0;
  logic [6:0] mon = '0;
  logic [2:0] boot = '0;
  logic [5:0] vds = '0;
  logic cur = 1'b0, overspeed_range_bit = 1'b0, nvm = 1'b1, pwm = 1'b0;
  logic [9:0] val [1:7] = '{10'h101, 10'h202, 10'h303, 10'h0c4, 10'h055, 10'h266, 10'h077};
  logic [15:0] r;
  int n_errors = 0, comparisons = 0, n_wr = 0;
  always #20 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    if (wr === 1'b1) begin
      n_wr++;
      wr_addr <= addr;
      wr_data <= wdata;
    end
  end
  sdr_status_diag_readback #(.REFRESH_CYC(RCYC)) i_dut (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .strobe_n_i(strobe_n), .sclk_i(sclk),
    .serial_data_in_i(serial_data_in), .serial_data_out_o(serial_data_out), .serial_data_oe_o(oe),
    .fault_flag_o(ff), .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_wr_o(wr),
    .reg_rdata_i(rdata), .cfg_readback_o(cfg), .crit_fault_i(crit),
    .monitor_fault_i(mon), .current_ctrl_i(cur), .bootstrap_uv_i(boot),
    .vds_ov_i(vds), .overspeed_i(overspeed_range_bit), .nvm_fault_i(nvm), .speed_i(val[1]),
    .avg_current_i(val[2]), .supply_volt_i(val[3]), .chip_temp_i(val[4]),
    .demand_value_i(val[5]), .peak_duty_i(val[6]), .phase_adv_i(val[7]),
    .pwm_period_i(pwm));
  sdr_link_master i_mst (.clk_sys_i(clk_sys_i), .strobe_n_o(strobe_n), .sclk_o(sclk),
    .sdi_o(serial_data_in), .sdo_i(serial_data_out), .oe_i(oe));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] fr(input logic [14:0] t);
    return {t, ~^t};
  endfunction
  task automatic go(input logic [4:0] a, input logic w, input logic [8:0] d);
    i_mst.xfer({a, w, d, 1'b0}, 16, 1'b0, r);
  endtask
  task automatic test_done;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic t_reset;
    go(5'h00, 1'b0, 9'h000);
    chk(r, fr({5'b11100, 1'b0, 9'h0a5}));
    chk(16'(n_wr), 16'h0000);
  endtask
  // Whether the memory fault stays latched one frame is open, so bit 13 is masked here
  task automatic t_write;
    nvm = 1'b0;
    go(5'h05, 1'b1, 9'h155);
    chk({2'b00, r[15:14], r[12:1]}, 16'h3000);
    chk({wr_addr, 2'b00, wr_data}, {5'h05, 2'b00, 9'h155});
    chk({15'h0000, ff}, 16'h0000);
  endtask
  task automatic t_poll;
    i_mst.xfer(16'h0000, 0, 1'b0, r);
    chk({15'h0000, r[15]}, 16'h0000);
    chk({14'h0000, oe, ff}, 16'h0000);
  endtask
  task automatic t_err;
    int k;
    int m;
    m = n_wr;
    for (k = 0; k < 3; k++) begin
      i_mst.xfer({5'h05, 1'b1, 9'h0ff, 1'b0}, 15 + k, k == 1, r);
      chk({15'h0000, ff}, 16'h0001);
      go(5'h05, 1'b1, 9'h000);
      chk(r, fr({5'b10100, 10'h000}));
    end
    chk(16'(n_wr - m), 16'h0003);
  endtask
  task automatic t_faults;
    cur = 1'b1;
    crit = 2'b10;
    overspeed_range_bit = 1'b1;
    boot = 3'b010;
    vds = 6'b000010;
    mon = 7'h01;
    repeat (3) @(posedge clk_sys_i);
    #1 boot = 3'b000;
    vds = 6'h00;
    mon = 7'h00;
    go(5'h05, 1'b1, 9'h000);
    chk(r, fr({5'b10011, 1'b0, 9'h007}));
    go(5'h1f, 1'b0, 9'h000);
    chk(r, fr({5'b10011, 10'h282}));
    overspeed_range_bit = 1'b0;
    crit = 2'b00;
    go(5'h05, 1'b1, 9'h000);
    chk(r, fr({5'b10011, 10'h000}));
    go(5'h1f, 1'b0, 9'h000);
    chk(r, fr({5'b00001, 10'h000}));
    cur = 1'b0;
  endtask
  task automatic t_dsr;
    go(5'h1d, 1'b1, 9'h020);
    chk({7'h00, cfg}, 16'h0020);
    mon = 7'h02;
    @(posedge clk_sys_i);
    #1 mon = 7'h00;
    repeat (2) begin
      go(5'h05, 1'b1, 9'h000);
      chk(r, fr({5'b10000, 1'b0, 9'h008}));
    end
    go(5'h1d, 1'b1, 9'h000);
    go(5'h05, 1'b1, 9'h000);
    go(5'h05, 1'b1, 9'h000);
    chk(r, fr(15'h0000));
  endtask
  // Duty and advance move after their sample, so a stale readback shows the hold works
  task automatic t_rbs;
    int s;
    pwm = 1'b1;
    @(posedge clk_sys_i);
    #1 pwm = 1'b0;
    val[6] = ~val[6];
    val[7] = ~val[7];
    repeat (2 * RCYC) @(posedge clk_sys_i);
    #1;
    for (s = 1; s < 8; s++) begin
      go(5'h1d, 1'b1, {6'h00, s[2:0]});
      go(5'h1f, 1'b0, 9'h000);
      chk(r, fr({5'h00, s > 5 ? ~val[s] : val[s]}));
    end
  endtask
  // A mid-run reset must bring back the power-on flag and the select defaults
  task automatic t_por;
    srst_i = 1'b1;
    repeat (4) @(posedge clk_sys_i);
    #1 srst_i = 1'b0;
    repeat (4) @(posedge clk_sys_i);
    #1;
    go(5'h1d, 1'b0, 9'h000);
    chk(r, fr({5'b11000, 1'b0, 9'h000}));
    chk({7'h00, cfg}, 16'h0000);
  endtask
  initial begin
    #3000000;
    n_errors++;
    test_done();
  end
  initial begin
    repeat (4) @(posedge clk_sys_i);
    #1 srst_i = 1'b0;
    repeat (4) @(posedge clk_sys_i);
    #1;
    t_reset();
    t_write();
    t_poll();
    t_err();
    t_faults();
    t_dsr();
    t_rbs();
    t_por();
    test_done();
  end
endmodule
`default_nettype wire
